/* File: xiu_core.sv */
// extended interrupt unit: flags, enables, levels, arbitration and vectoring
// assumes the cpu sequencer pulses done/reti/regwrite on mclk_i and fetches vector_o
`timescale 1ns/1ps
// Summary of operation
// - wakeup flag sets on pin-change or timer wakeup event
// - wakeup flag stays set on vectoring; software clears it, else requested again
// - software writing one to wakeup flag raises request when enabled
// - enable register: bit4 wakeup..bit0 converter; zero masks; bits 7-5 read one
// - level register: same order, one means high level; bits 7-5 read one
// - accepted request vectors to its fixed service address
// - return restores previous active level and resumes interrupted flow
// - routine pre-empted only by strictly higher level request
// - finish instruction; after return or enable/level write run one more
// - global enable zero masks every source
// - high level first, then natural order, pin 0 first
// - external pins sampled once per instruction cycle at phase four end
// - core timers and serial port request through their own flags
// - pin type zero: level sensitive, flag follows low sample
// - pin type one: flag set on high sample then low sample
// - level requests not latched; source holds pin until routine entered
// - radio and converter flags set on rising edges, serial after eight bits
// - extended sources natural priority 8 to 12, vectors 0x43 to 0x63
module xiu_core (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // external pins, active low
   input wire logic ext_irq_pin0_n_i,
   input wire logic ext_irq_pin1_n_i,
   // peripheral event sources
   input wire logic address_match_i,
   input wire logic radio_data_ready_i,
   input wire logic serial_byte_done_i,
   input wire logic conv_done_i,
   input wire logic wakeup_event_i,
   // core timer and serial flags, natural priority 1,3,4,5,6
   input wire logic [4:0] core_flag_i,
   input wire logic [4:0] core_enable_i,
   input wire logic [4:0] core_level_i,
   // cpu sequencer
   input wire logic instr_done_i,
   input wire logic instr_is_reti_i,
   input wire logic instr_wr_irq_reg_i,
   output logic vector_req_o,
   output logic [7:0] vector_o,
   output logic [1:0] active_level_o
);
   ////////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [4:0] ext_flag;
      logic [4:0] ext_en;
      logic [4:0] ext_lvl;
      logic glb_en;
      logic [1:0] pin_type;
      logic [1:0] pin_flag;
      logic [1:0] pin_lvl;
      logic [1:0] pin_en;
      logic [1:0] pin_prev;
      logic [1:0] pin_s1;
      logic [1:0] pin_s2;
      logic [1:0] phase;
      logic [3:0] periph_prev;
      logic extra_instr;
      logic [1:0] act;
      logic [1:0] act_stack;
      logic vreq;
      logic [7:0] vec;
      logic [31:0] rdata;
      logic ready;
      logic err;
   } xiu_state_t;

   xiu_state_t st;
   xiu_state_t next_st;

   // falling edge seen at this cycle's pin sample; lets an edge set beat the vector clear
   logic [1:0] pin_edge;
   assign pin_edge = {2{st.phase == xiu_pkg::PHASE_LAST}} & st.pin_prev & ~st.pin_s2;

   logic [xiu_pkg::NSRC-1:0] pend;
   logic [xiu_pkg::NSRC-1:0] hi;
   logic [4:0] periph_rise;
   logic [9:0] word_idx;
   logic wr_acc;
   logic rd_acc;
   logic [7:0] wb;

   // source vector by natural priority: 0 pin0,2 pin1,1,3..6 core,8..12 extended
   always_comb begin
      pend = '0;
      hi = '0;
      pend[0] = st.pin_flag[0] & st.pin_en[0];
      pend[2] = st.pin_flag[1] & st.pin_en[1];
      hi[0] = st.pin_lvl[0];
      hi[2] = st.pin_lvl[1];
      pend[1] = core_flag_i[0] & core_enable_i[0];
      hi[1] = core_level_i[0];
      for (int k = 1; k < 5; k++) begin
         pend[k + 2] = core_flag_i[k] & core_enable_i[k];
         hi[k + 2] = core_level_i[k];
      end
      for (int k = 0; k < 5; k++) begin
         pend[k + 8] = st.ext_flag[k] & st.ext_en[k];
         hi[k + 8] = st.ext_lvl[k];
      end
      if (!st.glb_en) begin
         pend = '0;
      end
   end

   assign periph_rise = {wakeup_event_i, address_match_i & ~st.periph_prev[3],
      radio_data_ready_i & ~st.periph_prev[2], serial_byte_done_i,
      conv_done_i & ~st.periph_prev[0]};
   assign word_idx = paddr_i[11:2];
   assign wr_acc = psel_i & penable_i & pwrite_i & ~st.ready;
   assign rd_acc = psel_i & penable_i & ~pwrite_i & ~st.ready;
   assign wb = pwdata_i[7:0];

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic found;
      logic [3:0] pick;
      logic pick_hi;
      logic [1:0] lvl_need;
      found = 1'b0;
      pick = 4'h0;
      pick_hi = 1'b0;
      lvl_need = 2'h0;
      next_st = st;
      next_st.vreq = 1'b0;
      next_st.ready = 1'b0;
      next_st.err = 1'b0;
      next_st.periph_prev = {address_match_i, radio_data_ready_i, 1'b0, conv_done_i};
      // two-flop synchroniser, then one sample per instruction cycle
      next_st.pin_s1 = {ext_irq_pin1_n_i, ext_irq_pin0_n_i};
      next_st.pin_s2 = st.pin_s1;
      next_st.phase = st.phase + 2'h1;
      // software access first so hardware sets below win over clears
      if (wr_acc) begin
         next_st.ready = 1'b1;
         case (word_idx[7:0])
            xiu_pkg::FLAG_IDX: next_st.ext_flag[3:0] = wb[7:4];
            xiu_pkg::CTRL_FLAG_IDX: next_st.ext_flag[4] = wb[xiu_pkg::WAKE_FLAG_BIT];
            xiu_pkg::ENABLE_IDX: next_st.ext_en = wb[4:0];
            xiu_pkg::LEVEL_IDX: next_st.ext_lvl = wb[4:0];
            xiu_pkg::GLOBAL_IDX: begin
               next_st.glb_en = wb[xiu_pkg::GLOBAL_EN_BIT];
               next_st.pin_en = {wb[2], wb[0]};
               next_st.pin_lvl = {wb[5], wb[4]};
            end
            xiu_pkg::TIMER_CTRL_IDX: begin
               next_st.pin_type = {wb[xiu_pkg::PIN1_TYPE_BIT], wb[xiu_pkg::PIN0_TYPE_BIT]};
               next_st.pin_flag = {wb[xiu_pkg::PIN1_FLAG_BIT], wb[xiu_pkg::PIN0_FLAG_BIT]};
            end
            default: next_st.err = 1'b1;
         endcase
         if (word_idx[9:8] != 2'h0) begin
            next_st.err = 1'b1;
         end
      end
      if (rd_acc) begin
         next_st.ready = 1'b1;
         next_st.rdata = 32'h0;
         case (word_idx[7:0])
            xiu_pkg::FLAG_IDX: next_st.rdata[7:0] = {st.ext_flag[3:0], xiu_pkg::FLAG_RSV[3:0]};
            xiu_pkg::CTRL_FLAG_IDX:
               next_st.rdata[7:0] = xiu_pkg::CTRL_RSV | {4'h0, st.ext_flag[4], 3'h0};
            xiu_pkg::ENABLE_IDX: next_st.rdata[7:0] = {xiu_pkg::EN_RSV[7:5], st.ext_en};
            xiu_pkg::LEVEL_IDX: next_st.rdata[7:0] = {xiu_pkg::EN_RSV[7:5], st.ext_lvl};
            xiu_pkg::GLOBAL_IDX:
               next_st.rdata[7:0] = {st.glb_en, 1'b0, st.pin_lvl, 1'b0, st.pin_en[1], 1'b0,
                  st.pin_en[0]};
            xiu_pkg::TIMER_CTRL_IDX:
               next_st.rdata[7:0] = {4'h0, st.pin_flag[1], st.pin_type[1], st.pin_flag[0],
                  st.pin_type[0]};
            xiu_pkg::STATUS_IDX: next_st.rdata[12:0] = pend;
            xiu_pkg::CPU_IDX: next_st.rdata[7:0] = {4'h0, st.act_stack, st.act};
            default: next_st.err = 1'b1;
         endcase
         if (word_idx[9:8] != 2'h0) begin
            next_st.err = 1'b1;
         end
      end
      // peripheral flags set by hardware
      for (int k = 0; k < 4; k++) begin
         if (periph_rise[k]) begin
            next_st.ext_flag[k] = 1'b1;
         end
      end
      if (periph_rise[4]) begin
         next_st.ext_flag[4] = 1'b1;
      end
      // pin sampling at the end of the fourth phase
      if (st.phase == xiu_pkg::PHASE_LAST) begin
         for (int p = 0; p < 2; p++) begin
            next_st.pin_prev[p] = st.pin_s2[p];
            if (!st.pin_type[p]) begin
               next_st.pin_flag[p] = ~st.pin_s2[p];
            end else if (st.pin_prev[p] & ~st.pin_s2[p]) begin
               next_st.pin_flag[p] = 1'b1;
            end
         end
      end
      // arbitration: high level first, then lowest natural index
      for (int k = xiu_pkg::NSRC - 1; k >= 0; k--) begin
         if (pend[k] & hi[k]) begin
            found = 1'b1;
            pick = 4'(k);
            pick_hi = 1'b1;
         end
      end
      if (!found) begin
         for (int k = xiu_pkg::NSRC - 1; k >= 0; k--) begin
            if (pend[k]) begin
               found = 1'b1;
               pick = 4'(k);
            end
         end
      end
      lvl_need = pick_hi ? 2'h2 : 2'h1;
      if (instr_done_i) begin
         next_st.extra_instr = instr_is_reti_i | instr_wr_irq_reg_i;
         if (instr_is_reti_i) begin
            next_st.act = st.act_stack;
            next_st.act_stack = 2'h0;
         end else if (found && !instr_wr_irq_reg_i && !st.extra_instr &&
               lvl_need > st.act) begin
            next_st.vreq = 1'b1;
            next_st.vec = xiu_pkg::VEC_BASE + 8'(pick) * xiu_pkg::VEC_STEP;
            next_st.act_stack = st.act;
            next_st.act = lvl_need;
            // vectoring clears edge-type pin flags; wakeup and other extended flags stay for software
            if (pick == 4'h0 && st.pin_type[0] && !pin_edge[0]) begin
               next_st.pin_flag[0] = 1'b0;
            end
            if (pick == 4'h2 && st.pin_type[1] && !pin_edge[1]) begin
               next_st.pin_flag[1] = 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= '0;
         st.pin_s1 <= 2'h3;
         st.pin_s2 <= 2'h3;
         st.pin_prev <= 2'h3;
      end else begin
         st <= next_st;
      end
   end

   assign prdata_o = st.rdata;
   assign pready_o = st.ready;
   assign pslverr_o = st.err;
   assign vector_req_o = st.vreq;
   assign vector_o = st.vec;
   assign active_level_o = st.act;

   ////////////////////////////////////////////////////////////////////////////////
   // flags and software access
   chk_wake_set: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) wakeup_event_i |=> st.ext_flag[4])
      else $error("wakeup flag not set");
   chk_wake_stays: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) vector_req_o && vector_o == 8'h63 |-> st.ext_flag[4])
      else $error("wakeup flag cleared on vector");
   chk_soft_wake: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) wr_acc && word_idx == {2'h0, xiu_pkg::CTRL_FLAG_IDX}
      && wb[xiu_pkg::WAKE_FLAG_BIT] |=> st.ext_flag[4]) else $error("software wakeup lost");
   chk_enable_rsv: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) rd_acc && word_idx == {2'h0, xiu_pkg::ENABLE_IDX}
      |=> prdata_o[7:5] == 3'h7) else $error("enable reserved bits not one");
   chk_level_rsv: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) rd_acc && word_idx == {2'h0, xiu_pkg::LEVEL_IDX}
      |=> prdata_o[7:5] == 3'h7) else $error("level reserved bits not one");
   chk_flag_rsv: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) rd_acc && word_idx == {2'h0, xiu_pkg::FLAG_IDX}
      |=> prdata_o[3:0] == 4'h8) else $error("flag reserved bits wrong");
   chk_ready_pulse: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   chk_err_ready: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) pslverr_o |-> pready_o)
      else $error("error without ready");
   chk_conv_edge: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) $rose(conv_done_i) |=> st.ext_flag[0])
      else $error("converter flag missed");
   chk_am_edge: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) $rose(address_match_i) |=> st.ext_flag[3])
      else $error("address match flag missed");
   chk_serial_set: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) serial_byte_done_i |=> st.ext_flag[1])
      else $error("serial flag missed");
   chk_reset_clear: assert property (
      @(posedge mclk_i) !rst_n_i |-> st.ext_en == 5'h00 && st.ext_lvl == 5'h00
      && st.ext_flag == 5'h00) else $error("reset left state");

   // vectoring and levels
   chk_vec_range: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) vector_req_o |-> vector_o[2:0] == 3'h3)
      else $error("bad vector");
   chk_vec_map: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) vector_req_o && vector_o == 8'h43
      |-> $past(st.ext_flag[0] && st.ext_en[0])) else $error("converter vector unrequested");
   chk_reti_restore: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) instr_done_i && instr_is_reti_i
      |=> active_level_o == $past(st.act_stack)) else $error("level not restored");
   chk_no_preempt_hi: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) $past(active_level_o) == 2'h2
      && !$past(instr_is_reti_i) |-> !vector_req_o) else $error("high routine pre-empted");
   chk_preempt_level: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) vector_req_o
      |-> active_level_o > $past(active_level_o)) else $error("pre-empted by equal level");
   chk_reti_extra: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) instr_done_i && st.extra_instr |=> !vector_req_o)
      else $error("vector without extra instruction");
   chk_wr_extra: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) instr_done_i
      && (instr_is_reti_i || instr_wr_irq_reg_i) |=> !vector_req_o) else $error("vector at return");
   chk_global_mask: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) !st.glb_en && instr_done_i |=> !vector_req_o)
      else $error("request passed global mask");
   chk_high_first: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) vector_req_o && $past((pend & hi) != '0)
      |-> active_level_o == 2'h2) else $error("low level chosen over high");
   chk_pin0_first: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) vector_req_o && $past(pend[0]
      && (hi[0] || (pend & hi) == '0)) |-> vector_o == 8'h03) else $error("pin 0 not first");
   chk_core_source: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) vector_req_o && vector_o == 8'h0b
      |-> $past(core_flag_i[0] && core_enable_i[0])) else $error("core vector unrequested");

   // pins
   chk_pin_phase: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) st.phase != xiu_pkg::PHASE_LAST |=> $stable(st.pin_prev))
      else $error("pin sampled off phase");
   chk_level_pin0: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) st.phase == xiu_pkg::PHASE_LAST && !st.pin_type[0]
      |=> st.pin_flag[0] == !$past(st.pin_s2[0])) else $error("pin 0 level flag wrong");
   chk_level_pin1: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) st.phase == xiu_pkg::PHASE_LAST && !st.pin_type[1]
      |=> st.pin_flag[1] == !$past(st.pin_s2[1])) else $error("pin 1 level flag wrong");
   chk_edge_pin0: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) pin_edge[0] && st.pin_type[0] |=> st.pin_flag[0])
      else $error("pin 0 edge missed");
   chk_edge_pin1: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) pin_edge[1] && st.pin_type[1] |=> st.pin_flag[1])
      else $error("pin 1 edge missed");
   chk_edge_quiet: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) st.phase != xiu_pkg::PHASE_LAST && !wr_acc
      && !st.pin_flag[0] |=> !st.pin_flag[0]) else $error("pin 0 flag set off sample");

   // main scenarios
   cov_vector: cover property (@(posedge mclk_i) vector_req_o);
   cov_nested: cover property (@(posedge mclk_i) vector_req_o && st.act_stack == 2'h1);
   cov_reti: cover property (@(posedge mclk_i) instr_done_i && instr_is_reti_i);
   cov_wake_vec: cover property (@(posedge mclk_i) vector_req_o && vector_o == 8'h63);
   cov_edge_pin: cover property (@(posedge mclk_i) vector_req_o && vector_o == 8'h03
      && st.pin_type[0]);
endmodule

/* File: xiu_pkg.sv */
// package for the extended interrupt unit: register offsets, field positions, reset values
// assumes an apb slave with 32-bit data; each register one word at byte address 4 * index
package xiu_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] FLAG_IDX = 8'h91;
   localparam logic [7:0] CTRL_FLAG_IDX = 8'hd8;
   localparam logic [7:0] ENABLE_IDX = 8'he8;
   localparam logic [7:0] LEVEL_IDX = 8'hf8;
   localparam logic [7:0] GLOBAL_IDX = 8'ha8;
   localparam logic [7:0] TIMER_CTRL_IDX = 8'h88;
   localparam logic [7:0] STATUS_IDX = 8'h40;
   localparam logic [7:0] CPU_IDX = 8'h41;
   // field positions
   localparam int FLAG_LSB = 4;
   localparam int WAKE_FLAG_BIT = 3;
   localparam int GLOBAL_EN_BIT = 7;
   localparam int PIN0_TYPE_BIT = 0;
   localparam int PIN1_TYPE_BIT = 2;
   localparam int PIN0_FLAG_BIT = 1;
   localparam int PIN1_FLAG_BIT = 3;
   localparam int NSRC = 13;
   // read-as-one patterns of reserved bits
   localparam logic [7:0] FLAG_RSV = 8'h08;
   localparam logic [7:0] CTRL_RSV = 8'h40;
   localparam logic [7:0] EN_RSV = 8'he0;
   // reset value and last sampling phase
   localparam logic [4:0] EXT_RST = 5'h00;
   localparam logic [1:0] PHASE_LAST = 2'h3;
   // vector addresses by natural priority
   localparam logic [7:0] VEC_BASE = 8'h03;
   localparam logic [7:0] VEC_STEP = 8'h08;
endpackage

/* File: xiu_seq_model.sv */
// cpu sequencer model: one instruction ends every fourth clock
// assumes the bench asks for return or irq register write instructions by level
`timescale 1ns/1ps
module xiu_seq_model (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // requests from the bench
   input wire logic reti_req_i,
   input wire logic wr_req_i,
   // to the interrupt unit
   output logic instr_done_o,
   output logic instr_is_reti_o,
   output logic instr_wr_irq_reg_o
);
   logic [1:0] phase;
   ////////////////////////////////////////////////////////////
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase <= 2'h0;
         instr_done_o <= 1'b0;
         instr_is_reti_o <= 1'b0;
         instr_wr_irq_reg_o <= 1'b0;
      end else begin
         phase <= phase + 2'h1;
         instr_done_o <= (phase == 2'h3);
         instr_is_reti_o <= (phase == 2'h3) && reti_req_i;
         instr_wr_irq_reg_o <= (phase == 2'h3) && wr_req_i;
      end
   end
endmodule

/* File: extended_interrupt_unit_tb_top.sv */
// self-checking bench for the extended interrupt unit
// assumes xiu_pkg, xiu_core and xiu_seq_model are compiled before it
`timescale 1ns/1ps
module extended_interrupt_unit_tb_top;
   logic mclk_i, rst_n_i, psel, penable, pwrite, pready, pslverr, pin0_n, pin1_n, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [4:0] src, core_flag, core_en, core_lvl;
   logic done, is_reti, is_wr, reti_req, wr_req, vreq;
   logic [7:0] vec;
   logic [1:0] act;
   int miscompares = 0;
   int num_checks = 0;
   int a, b, lv, w;
   ////////////////////////////////////////////////////////////
   xiu_core DUT (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .ext_irq_pin0_n_i(pin0_n),
      .ext_irq_pin1_n_i(pin1_n), .address_match_i(src[3]), .radio_data_ready_i(src[2]),
      .serial_byte_done_i(src[1]), .conv_done_i(src[0]), .wakeup_event_i(src[4]),
      .core_flag_i(core_flag), .core_enable_i(core_en), .core_level_i(core_lvl),
      .instr_done_i(done), .instr_is_reti_i(is_reti), .instr_wr_irq_reg_i(is_wr),
      .vector_req_o(vreq), .vector_o(vec), .active_level_o(act)
   );
   xiu_seq_model seq (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reti_req_i(reti_req), .wr_req_i(wr_req),
      .instr_done_o(done), .instr_is_reti_o(is_reti), .instr_wr_irq_reg_o(is_wr)
   );
   initial begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end
   ////////////////////////////////////////////////////////////
   // reference arbiter: highest level first, then lowest natural index
   function automatic int pick(int pend, int lvl);
      int v = -1;
      for (int n = 12; n >= 0; n--) begin
         if (pend[n] && (v < 0 || lvl[n] >= lvl[v])) v = n;
      end
      return v;
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
      int n = 0;
      @(posedge mclk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= d;
      @(posedge mclk_i);
      penable <= 1'b1;
      do begin
         @(posedge mclk_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk("pready", 32'h1, 32'(pready === 1'b1));
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(what, exp, rd);
   endtask
   task automatic pulse(input int i);
      src <= 5'(1 << i);
      @(posedge mclk_i);
      src <= 5'h00;
   endtask
   task automatic wait_vec(input logic [7:0] v, input logic [1:0] l);
      int n = 0;
      while (vreq !== 1'b1 && n < 40) begin
         @(posedge mclk_i);
         n++;
      end
      chk("vector request", 32'h1, 32'(vreq === 1'b1));
      chk("vector", 32'(v), 32'(vec));
      chk("active level", 32'(l), 32'(act));
   endtask
   task automatic no_vec(input int n);
      int hits = 0;
      repeat (n) begin
         @(posedge mclk_i);
         if (vreq === 1'b1) hits++;
      end
      chk("no vector", 32'h0, 32'(hits));
   endtask
   task automatic do_reti(input logic [1:0] l);
      int n = 0;
      reti_req <= 1'b1;
      do begin
         @(posedge mclk_i);
         n++;
      end while (!(done === 1'b1 && is_reti === 1'b1) && n < 20);
      chk("return done", 32'h1, 32'(done === 1'b1 && is_reti === 1'b1));
      reti_req <= 1'b0;
      repeat (2) @(posedge mclk_i);
      chk("restored level", 32'(l), 32'(act));
   endtask
   task automatic clr();
      apb(1'b1, xiu_pkg::FLAG_IDX, 32'h0);
      apb(1'b1, xiu_pkg::CTRL_FLAG_IDX, 32'h0);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge mclk_i);
      miscompares++;
      print_verdict();
   end
   ////////////////////////////////////////////////////////////
   initial begin
      rst_n_i = 1'b0;
      {psel, penable, pwrite, reti_req, wr_req, paddr, pwdata} = '0;
      {src, core_flag, core_en, core_lvl} = '0;
      {pin0_n, pin1_n} = 2'b11;
      void'($urandom(32'h86b1));
      repeat (2) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      rdchk("enable", xiu_pkg::ENABLE_IDX, 32'he0);
      rdchk("level", xiu_pkg::LEVEL_IDX, 32'he0);
      rdchk("ctrl flag", xiu_pkg::CTRL_FLAG_IDX, 32'h40);
      rdchk("flag", xiu_pkg::FLAG_IDX, 32'h08);
      apb(1'b0, 8'h00, 32'h0);
      chk("unmapped", 32'h1, 32'(err));
      apb(1'b1, xiu_pkg::LEVEL_IDX, 32'h15);
      rdchk("level", xiu_pkg::LEVEL_IDX, 32'hf5);
      apb(1'b1, xiu_pkg::LEVEL_IDX, 32'h0);
      apb(1'b1, xiu_pkg::ENABLE_IDX, 32'h01);
      rdchk("enable", xiu_pkg::ENABLE_IDX, 32'he1);
      pulse(0);
      rdchk("flag", xiu_pkg::FLAG_IDX, 32'h18);
      no_vec(16);
      apb(1'b1, xiu_pkg::GLOBAL_IDX, 32'h80);
      wait_vec(8'h43, 2'h1);
      clr();
      do_reti(2'h0);
      $display("test masking done");
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, xiu_pkg::ENABLE_IDX, 32'(1 << i));
         pulse(i);
         wait_vec(8'(8'h43 + 8 * i), 2'h1);
         clr();
         do_reti(2'h0);
      end
      $display("test sources done");
      apb(1'b1, xiu_pkg::CTRL_FLAG_IDX, 32'h08);
      wait_vec(8'h63, 2'h1);
      do_reti(2'h0);
      no_vec(5);
      wait_vec(8'h63, 2'h1);
      clr();
      do_reti(2'h0);
      no_vec(16);
      wr_req <= 1'b1;
      apb(1'b1, xiu_pkg::CTRL_FLAG_IDX, 32'h08);
      no_vec(16);
      wr_req <= 1'b0;
      wait_vec(8'h63, 2'h1);
      clr();
      do_reti(2'h0);
      $display("test wakeup done");
      apb(1'b1, xiu_pkg::ENABLE_IDX, 32'h11);
      apb(1'b1, xiu_pkg::LEVEL_IDX, 32'h10);
      apb(1'b1, xiu_pkg::FLAG_IDX, 32'h10);
      wait_vec(8'h43, 2'h1);
      apb(1'b1, xiu_pkg::CTRL_FLAG_IDX, 32'h08);
      wait_vec(8'h63, 2'h2);
      apb(1'b1, xiu_pkg::CTRL_FLAG_IDX, 32'h0);
      do_reti(2'h1);
      apb(1'b1, xiu_pkg::FLAG_IDX, 32'h0);
      do_reti(2'h0);
      $display("test nesting done");
      apb(1'b1, xiu_pkg::ENABLE_IDX, 32'h0f);
      repeat (4) begin
         a = $urandom_range(3);
         b = (a + 1 + $urandom_range(2)) % 4;
         lv = $urandom_range(15);
         apb(1'b1, xiu_pkg::LEVEL_IDX, 32'(lv));
         apb(1'b1, xiu_pkg::FLAG_IDX, 32'((1 << (4 + a)) | (1 << (4 + b))));
         w = pick((1 << (8 + a)) | (1 << (8 + b)), lv << 8);
         wait_vec(8'(3 + 8 * w), 2'(1 + lv[w - 8]));
         no_vec(12);
         a = (w == 8 + a) ? b : a;
         apb(1'b1, xiu_pkg::FLAG_IDX, 32'(1 << (4 + a)));
         do_reti(2'h0);
         wait_vec(8'(67 + 8 * a), 2'(1 + lv[a]));
         apb(1'b1, xiu_pkg::FLAG_IDX, 32'h0);
         do_reti(2'h0);
      end
      $display("test priority done");
      core_en <= 5'h01;
      core_flag <= 5'h01;
      wait_vec(8'h0b, 2'h1);
      core_flag <= 5'h00;
      do_reti(2'h0);
      apb(1'b1, xiu_pkg::GLOBAL_IDX, 32'h01);
      pin0_n <= 1'b0;
      apb(1'b1, xiu_pkg::FLAG_IDX, 32'h10);
      apb(1'b1, xiu_pkg::GLOBAL_IDX, 32'h81);
      wait_vec(8'h03, 2'h1);
      pin0_n <= 1'b1;
      do_reti(2'h0);
      wait_vec(8'h43, 2'h1);
      apb(1'b1, xiu_pkg::FLAG_IDX, 32'h0);
      do_reti(2'h0);
      apb(1'b1, xiu_pkg::TIMER_CTRL_IDX, 32'h01);
      repeat (4) @(posedge mclk_i);
      pin0_n <= 1'b0;
      wait_vec(8'h03, 2'h1);
      do_reti(2'h0);
      no_vec(20);
      pin0_n <= 1'b1;
      $display("test pins done");
      print_verdict();
   end
endmodule
